// File: verilog/adc_link_map.svh
`ifndef ADC_LINK_MAP_SVH
`define ADC_LINK_MAP_SVH

`define ADC_WIDTH 16
`define CLK_PERIOD_NS 4
`define CONV_TYP_NS 812
`define CONV_MAX_NS 853
`define ACQ_MIN_NS 813
`define CNV_HIGH_MIN_NS 9
`define CONV_CYCLES ((`CONV_TYP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CONV_WAIT_CYCLES ((`CONV_MAX_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ACQ_CYCLES ((`ACQ_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CNV_HIGH_CYCLES ((`CNV_HIGH_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SYNC_MARGIN_CYCLES 8
`define SCK_HALF_CYCLES 8
`define FIFO_DEPTH 16
`define PULLUP_LEVEL 1'b1

`endif

// File: verilog/adc_link_pkg.sv
package adc_link_pkg;

   typedef enum logic [2:0] {
      DEV_IDLE = 3'h0,
      DEV_CONV = 3'h1,
      DEV_WAIT = 3'h2,
      DEV_SHIFT = 3'h3,
      DEV_CHAIN = 3'h4
   } dev_state_t;

   typedef enum logic [2:0] {
      HOST_IDLE = 3'h0,
      HOST_START = 3'h1,
      HOST_CONV = 3'h2,
      HOST_SEL = 3'h3,
      HOST_HIGH = 3'h4,
      HOST_LOW = 3'h5,
      HOST_ACQ = 3'h6
   } host_state_t;

endpackage : adc_link_pkg

// File: verilog/adc_link_if.sv
`include "adc_link_map.svh"
interface adc_link_if;
   logic conversionStart;
   logic shiftClk;
   logic serialInSelect;
   logic resultOut;
   logic resultOe;
   logic serialResultOut;

   // A pull-up holds the shared line high while the device releases it.
   assign serialResultOut = resultOe ? resultOut : `PULLUP_LEVEL;

   modport device (
      input conversionStart,
      input shiftClk,
      input serialInSelect,
      output resultOut,
      output resultOe
   );

   modport host (
      output conversionStart,
      output shiftClk,
      output serialInSelect,
      input serialResultOut
   );
endinterface : adc_link_if

// File: verilog/sync_fifo.sv
`include "adc_link_map.svh"
module sync_fifo #(
   parameter int Width = `ADC_WIDTH,
   parameter int Depth = `FIFO_DEPTH
) (
   input wire logic sys_clk, // System clock.
   input wire logic sys_rst, // Synchronous reset, active high.
   input wire logic inValid, // Write word offered.
   input wire logic [Width-1:0] inData, // Write word.
   output logic inReady, // Space for a word.
   output logic outValid, // Read word present.
   output logic [Width-1:0] outData, // Oldest word.
   input wire logic outReady // Reader takes the word.
);
   localparam int PtrW = $clog2(Depth);
   localparam int CntW = $clog2(Depth + 1);

   logic [Width-1:0] mem [Depth];
   logic [PtrW-1:0] wrPtr_reg, wrPtr_next, rdPtr_reg, rdPtr_next;
   logic [CntW-1:0] count_reg, count_next;
   logic push, pop;

   assign inReady = (count_reg != CntW'(Depth));
   assign outValid = (count_reg != '0);
   assign outData = mem[rdPtr_reg];
   assign push = inValid & inReady;
   assign pop = outValid & outReady;

   // Depth is taken as a power of two so the pointers wrap by themselves.
   always_comb
   begin
      wrPtr_next = wrPtr_reg + PtrW'(push);
      rdPtr_next = rdPtr_reg + PtrW'(pop);
      count_next = count_reg + CntW'(push) - CntW'(pop);
   end

   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         wrPtr_reg <= '0;
         rdPtr_reg <= '0;
         count_reg <= '0;
      end
      else
      begin
         wrPtr_reg <= wrPtr_next;
         rdPtr_reg <= rdPtr_next;
         count_reg <= count_next;
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (push)
      begin
         mem[wrPtr_reg] <= inData;
      end
   end
endmodule : sync_fifo

// File: verilog/adc_device_end.sv
`include "adc_link_map.svh"
module adc_device_end #(
   parameter int DataWidth = `ADC_WIDTH,
   parameter int ConvCycles = `CONV_CYCLES
) (
   input wire logic sys_clk, // System clock, 250 MHz.
   input wire logic sys_rst, // Synchronous reset, active high.
   adc_link_if.device link, // Serial link pins.
   input wire logic [DataWidth-1:0] analogCode, // Input code to sample.
   output logic convBusy // Conversion in progress.
);
   localparam int CntW = $clog2(DataWidth + 2);
   localparam int TimW = $clog2(ConvCycles + 1);

   // Link pins come from another domain and pass two flops first.
   logic [2:0] sync1_reg, sync2_reg, prev_reg;
   logic cnvS, sckS, sdiS, cnvP, sckP, sdiP;
   logic cnvRise, sckFall, selActive, selStart;

   adc_link_pkg::dev_state_t state_reg, state_next;
   logic [DataWidth-1:0] shift_reg, shift_next;
   logic [TimW-1:0] timer_reg, timer_next;
   logic [CntW-1:0] count_reg, count_next;
   logic [CntW-1:0] limit_reg, limit_next;
   logic chain_reg, chain_next;
   logic busyBit_reg, busyBit_next;
   logic out_reg, out_next;
   logic oe_reg, oe_next;
   logic convBusy_reg, convBusy_next;

   assign {cnvS, sckS, sdiS} = sync2_reg;
   assign {cnvP, sckP, sdiP} = prev_reg;
   assign cnvRise = cnvS & ~cnvP;
   assign sckFall = ~sckS & sckP;
   // Three-wire ties select high so start low selects; four-wire holds
   // start high so select low selects. One term serves both.
   assign selActive = ~(cnvS & sdiS);
   assign selStart = selActive & (cnvP & sdiP);

   assign link.resultOut = out_reg;
   assign link.resultOe = oe_reg;
   assign convBusy = convBusy_reg;

   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         sync1_reg <= 3'h0;
         sync2_reg <= 3'h0;
         prev_reg <= 3'h0;
      end
      else
      begin
         sync1_reg <= {link.conversionStart, link.shiftClk,
                       link.serialInSelect};
         sync2_reg <= sync1_reg;
         prev_reg <= sync2_reg;
      end
   end

   always_comb
   begin
      state_next = state_reg;
      shift_next = shift_reg;
      timer_next = timer_reg;
      count_next = count_reg;
      limit_next = limit_reg;
      chain_next = chain_reg;
      busyBit_next = busyBit_reg;
      oe_next = oe_reg;
      unique case (state_reg)
         adc_link_pkg::DEV_IDLE:
         begin
            oe_next = 1'b0;
         end
         adc_link_pkg::DEV_CONV:
         begin
            // Runs on the local clock only; start edges are ignored, and start and select are read only at the end.
            timer_next = timer_reg + TimW'(1);
            if (timer_reg == TimW'(ConvCycles - 1))
            begin
               timer_next = '0;
               count_next = '0;
               if (chain_reg)
               begin
                  state_next = adc_link_pkg::DEV_CHAIN;
                  oe_next = 1'b1;
               end
               else if (selActive)
               begin
                  busyBit_next = 1'b1;
                  limit_next = CntW'(DataWidth + 1);
                  state_next = adc_link_pkg::DEV_SHIFT;
                  oe_next = 1'b1;
               end
               else
               begin
                  busyBit_next = 1'b0;
                  limit_next = CntW'(DataWidth);
                  state_next = adc_link_pkg::DEV_WAIT;
               end
            end
         end
         adc_link_pkg::DEV_WAIT:
         begin
            if (selStart)
            begin
               state_next = adc_link_pkg::DEV_SHIFT;
               oe_next = 1'b1;
            end
         end
         adc_link_pkg::DEV_SHIFT:
         begin
            if (!selActive)
            begin
               state_next = adc_link_pkg::DEV_IDLE;
               oe_next = 1'b0;
            end
            else if (sckFall)
            begin
               count_next = count_reg + CntW'(1);
               if (busyBit_reg)
               begin
                  busyBit_next = 1'b0;
               end
               else
               begin
                  shift_next = {shift_reg[DataWidth-2:0], 1'b0};
               end
               if (count_next == limit_reg)
               begin
                  state_next = adc_link_pkg::DEV_IDLE;
                  oe_next = 1'b0;
               end
            end
         end
         adc_link_pkg::DEV_CHAIN:
         begin
            if (!cnvS)
            begin
               state_next = adc_link_pkg::DEV_IDLE;
               oe_next = 1'b0;
            end
            else if (sckFall)
            begin
               if (busyBit_reg)
               begin
                  busyBit_next = 1'b0;
               end
               else
               begin
                  shift_next = {shift_reg[DataWidth-2:0], sdiS};
               end
            end
         end
         default:
         begin
            state_next = adc_link_pkg::DEV_IDLE;
            oe_next = 1'b0;
         end
      endcase
      // A start edge outside a conversion always begins a new one.
      if (cnvRise && state_reg != adc_link_pkg::DEV_CONV)
      begin
         state_next = adc_link_pkg::DEV_CONV;
         oe_next = 1'b0;
         timer_next = '0;
         shift_next = analogCode;
         chain_next = ~sdiS;
         // In the chain a high shift clock at the start edge asks for
         // the busy bit.
         busyBit_next = ~sdiS & sckS;
      end
      // The bit changes only after a falling edge, so it holds across
      // the following rise and up to the next fall.
      out_next = ~busyBit_next & shift_next[DataWidth-1];
      convBusy_next = (state_next == adc_link_pkg::DEV_CONV);
   end

   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         state_reg <= adc_link_pkg::DEV_IDLE;
         shift_reg <= '0;
         timer_reg <= '0;
         count_reg <= '0;
         limit_reg <= '0;
         chain_reg <= 1'b0;
         busyBit_reg <= 1'b0;
         out_reg <= 1'b0;
         oe_reg <= 1'b0;
         convBusy_reg <= 1'b0;
      end
      else
      begin
         state_reg <= state_next;
         shift_reg <= shift_next;
         timer_reg <= timer_next;
         count_reg <= count_next;
         limit_reg <= limit_next;
         chain_reg <= chain_next;
         busyBit_reg <= busyBit_next;
         out_reg <= out_next;
         oe_reg <= oe_next;
         convBusy_reg <= convBusy_next;
      end
   end
endmodule : adc_device_end

// File: verilog/adc_host_end.sv
`include "adc_link_map.svh"
module adc_host_end #(
   parameter int DataWidth = `ADC_WIDTH,
   parameter int Depth = `FIFO_DEPTH,
   parameter int HalfCycles = `SCK_HALF_CYCLES
) (
   input wire logic sys_clk, // System clock, 250 MHz.
   input wire logic sys_rst, // Synchronous reset, active high.
   adc_link_if.host link, // Serial link pins.
   input wire logic startReq, // Level: run conversions.
   output logic [DataWidth-1:0] resultData, // Oldest result.
   output logic resultValid, // Result present.
   input wire logic resultReady, // User takes the result.
   output logic readBusy // Cycle in progress.
);
   localparam int TimW = 12;
   localparam int BitW = $clog2(DataWidth + 1);

   adc_link_pkg::host_state_t state_reg, state_next;
   logic [TimW-1:0] timer_reg, timer_next;
   logic [BitW-1:0] bits_reg, bits_next;
   logic [DataWidth-1:0] word_reg, word_next;
   logic cnv_reg, cnv_next, sck_reg, sck_next;
   logic push_reg, push_next, busy_reg, busy_next;
   logic sdo1_reg, sdo2_reg;
   logic fifoReady;

   // Three-wire readout: select stays high.
   assign link.serialInSelect = 1'b1;
   assign link.conversionStart = cnv_reg;
   assign link.shiftClk = sck_reg;
   assign readBusy = busy_reg;

   sync_fifo #(.Width(DataWidth), .Depth(Depth)) resultFifo (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .inValid(push_reg),
      .inData(word_reg),
      .inReady(fifoReady),
      .outValid(resultValid),
      .outData(resultData),
      .outReady(resultReady)
   );

   always_comb
   begin
      state_next = state_reg;
      timer_next = timer_reg + TimW'(1);
      bits_next = bits_reg;
      word_next = word_reg;
      cnv_next = cnv_reg;
      sck_next = sck_reg;
      push_next = 1'b0;
      unique case (state_reg)
         adc_link_pkg::HOST_IDLE:
         begin
            timer_next = '0;
            // A full FIFO stalls new conversions, so no result is lost.
            if (startReq && fifoReady && !push_reg)
            begin
               state_next = adc_link_pkg::HOST_START;
               cnv_next = 1'b1;
            end
         end
         adc_link_pkg::HOST_START:
         begin
            // Start stays high through the conversion: no busy bit.
            if (timer_reg == TimW'(`CNV_HIGH_CYCLES - 1))
            begin
               state_next = adc_link_pkg::HOST_CONV;
               timer_next = '0;
            end
         end
         adc_link_pkg::HOST_CONV:
         begin
            if (timer_reg == TimW'(`CONV_WAIT_CYCLES
                                 + `SYNC_MARGIN_CYCLES))
            begin
               state_next = adc_link_pkg::HOST_SEL;
               cnv_next = 1'b0;
               timer_next = '0;
               bits_next = '0;
            end
         end
         adc_link_pkg::HOST_SEL:
         begin
            if (timer_reg == TimW'(`SYNC_MARGIN_CYCLES))
            begin
               state_next = adc_link_pkg::HOST_HIGH;
               sck_next = 1'b1;
               timer_next = '0;
            end
         end
         adc_link_pkg::HOST_HIGH:
         begin
            if (timer_reg == TimW'(HalfCycles - 1))
            begin
               // Capture just before the fall, where the bit is settled.
               word_next = {word_reg[DataWidth-2:0], sdo2_reg};
               bits_next = bits_reg + BitW'(1);
               sck_next = 1'b0;
               timer_next = '0;
               state_next = adc_link_pkg::HOST_LOW;
            end
         end
         adc_link_pkg::HOST_LOW:
         begin
            if (timer_reg == TimW'(HalfCycles - 1))
            begin
               timer_next = '0;
               if (bits_reg == BitW'(DataWidth))
               begin
                  // Start stays low: a rise here would begin a
                  // conversion whose result nobody reads.
                  push_next = 1'b1;
                  state_next = adc_link_pkg::HOST_ACQ;
               end
               else
               begin
                  sck_next = 1'b1;
                  state_next = adc_link_pkg::HOST_HIGH;
               end
            end
         end
         adc_link_pkg::HOST_ACQ:
         begin
            if (timer_reg == TimW'(`ACQ_CYCLES))
            begin
               cnv_next = 1'b0;
               state_next = adc_link_pkg::HOST_IDLE;
            end
         end
         default:
         begin
            state_next = adc_link_pkg::HOST_IDLE;
         end
      endcase
      busy_next = (state_next != adc_link_pkg::HOST_IDLE);
   end

   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         state_reg <= adc_link_pkg::HOST_IDLE;
         timer_reg <= '0;
         bits_reg <= '0;
         word_reg <= '0;
         cnv_reg <= 1'b0;
         sck_reg <= 1'b0;
         push_reg <= 1'b0;
         busy_reg <= 1'b0;
         sdo1_reg <= 1'b1;
         sdo2_reg <= 1'b1;
      end
      else
      begin
         state_reg <= state_next;
         timer_reg <= timer_next;
         bits_reg <= bits_next;
         word_reg <= word_next;
         cnv_reg <= cnv_next;
         sck_reg <= sck_next;
         push_reg <= push_next;
         busy_reg <= busy_next;
         sdo1_reg <= link.serialResultOut;
         sdo2_reg <= sdo1_reg;
      end
   end
endmodule : adc_host_end

// File: sim/sar_adc_serial_readout_checker.sv
module sar_adc_serial_readout_checker (
   input wire logic sys_clk, // System clock.
   input wire logic sys_rst, // Synchronous reset.
   input wire logic conversionStart, // Start line.
   input wire logic shiftClk, // Shift clock.
   input wire logic serialInSelect, // Select line.
   input wire logic resultOut, // Device data bit.
   input wire logic resultOe, // Device drive enable.
   input wire logic serialResultOut // Resolved line.
);
   logic seen_reg;
   logic seen_next;
   logic sckOld_reg;
   logic sckOld_next;
   logic [4:0] falls_reg;
   logic [4:0] falls_next;
   always_comb
   begin
      seen_next = (seen_reg | conversionStart) & ~sys_rst;
      sckOld_next = shiftClk & ~sys_rst;
      falls_next = falls_reg;
      if (sys_rst || conversionStart)
         falls_next = 5'h00;
      else if (sckOld_reg && !shiftClk && falls_reg != 5'h1F)
         falls_next = falls_reg + 5'h01;
   end
   always_ff @(posedge sys_clk)
   begin
      seen_reg <= seen_next;
      sckOld_reg <= sckOld_next;
      falls_reg <= falls_next;
   end
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (sys_rst);
   reset_idle_a: assert property (!seen_reg |-> !resultOe)
      else $error("output driven before any start");
   start_release_a: assert property (
      $rose(conversionStart) |-> ##[0:4] !resultOe)
      else $error("output not released at start");
   high_release_a: assert property (
      conversionStart [*5] |-> !resultOe)
      else $error("output driven while start high");
   enable_on_fall_a: assert property (
      $rose(resultOe) |-> !conversionStart
      && !$past(conversionStart, 3) && $past(conversionStart, 7))
      else $error("output enabled without start fall");
   bit_after_fall_a: assert property (
      resultOe && $past(resultOe) && $changed(resultOut)
      |-> !shiftClk && $past(shiftClk, 7))
      else $error("data bit moved without shift fall");
   bit_stable_a: assert property (
      $rose(shiftClk) |-> $stable(resultOut) [*6])
      else $error("data bit moved near shift rise");
   sixteen_falls_a: assert property (
      falls_reg == 5'h10 |-> ##[0:5] !resultOe)
      else $error("output held past sixteenth fall");
   select_high_a: assert property (
      $rose(conversionStart) |-> serialInSelect)
      else $error("select low at start rise");
   pulse_width_a: assert property (
      $rose(conversionStart) |=> conversionStart [*2])
      else $error("start pulse too short");
   cover property ($rose(resultOe));
   cover property (falls_reg == 5'h10);
   cover property ($rose(conversionStart));
endmodule : sar_adc_serial_readout_checker

// File: sim/sar_adc_serial_readout_tb_top.sv
module sar_adc_serial_readout_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [15:0] analogCode = 16'h0000;
   logic [15:0] codeB = 16'h0000;
   logic startReq = 1'b0;
   logic resultReady = 1'b0;
   logic cnvB = 1'b0;
   logic sckB = 1'b0;
   logic selB = 1'b1;
   logic [15:0] resultData;
   logic resultValid;
   logic readBusy;
   logic convBusy;
   logic convBusyB;
   logic [15:0] wireWord = 16'h0000;
   int capCnt = 0;
   int error_cnt = 0;
   int checks_done = 0;
   adc_link_if link ();
   adc_link_if linkB ();
   // The second device faces the bench, which plays a host in other modes.
   assign linkB.conversionStart = cnvB;
   assign linkB.shiftClk = sckB;
   assign linkB.serialInSelect = selB;
   adc_device_end u_adc_device_end (.sys_clk(sys_clk), .sys_rst(sys_rst),
      .link(link.device), .analogCode(analogCode), .convBusy(convBusy));
   adc_host_end u_adc_host_end (.sys_clk(sys_clk), .sys_rst(sys_rst),
      .link(link.host), .startReq(startReq), .resultData(resultData),
      .resultValid(resultValid), .resultReady(resultReady),
      .readBusy(readBusy));
   adc_device_end u_adc_device_end_b (.sys_clk(sys_clk), .sys_rst(sys_rst),
      .link(linkB.device), .analogCode(codeB), .convBusy(convBusyB));
   sar_adc_serial_readout_checker u_checker (.sys_clk(sys_clk),
      .sys_rst(sys_rst), .conversionStart(link.conversionStart),
      .shiftClk(link.shiftClk), .serialInSelect(link.serialInSelect),
      .resultOut(link.resultOut), .resultOe(link.resultOe),
      .serialResultOut(link.serialResultOut));
   initial
   begin
      forever #2 sys_clk = ~sys_clk;
   end
   always @(posedge link.shiftClk)
   begin
      if (link.resultOe)
      begin
         wireWord <= {wireWord[14:0], link.serialResultOut};
         capCnt <= capCnt + 1;
      end
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task automatic end_of_test();
      $display("errors=%0d checks=%0d", error_cnt, checks_done);
      if (error_cnt == 0 && checks_done > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : end_of_test
   task automatic stall(input int n, input int lim);
      if (n >= lim)
      begin
         error_cnt++;
         end_of_test();
      end
   endtask : stall
   task automatic pop();
      @(negedge sys_clk);
      resultReady = 1'b1;
      @(negedge sys_clk);
      resultReady = 1'b0;
   endtask : pop
   task automatic codes();
      logic [15:0] tbl [4] = '{16'h7FFF, 16'h0000, 16'hFFFF, 16'h8000};
      int n;
      foreach (tbl[i])
      begin
         analogCode = tbl[i];
         capCnt = 0;
         startReq = 1'b1;
         // The host may still sit out the acquisition wait from before.
         for (n = 0; n < 400 && convBusy !== 1'b1; n++) @(negedge sys_clk);
         stall(n, 400);
         check(readBusy, 1'b1);
         analogCode = ~tbl[i];
         startReq = 1'b0;
         for (n = 0; n < 900 && resultValid !== 1'b1; n++) @(negedge sys_clk);
         stall(n, 900);
         check(resultData, tbl[i]);
         check(wireWord, tbl[i]);
         check(capCnt, 16);
         pop();
      end
   endtask : codes
   task automatic fill_drain();
      int rises;
      logic prevBusy;
      rises = 0;
      prevBusy = 1'b0;
      analogCode = 16'h0000;
      startReq = 1'b1;
      // Each conversion samples the code that stood at its start edge.
      repeat (14000)
      begin
         @(negedge sys_clk);
         if (convBusy === 1'b1 && prevBusy !== 1'b1)
         begin
            rises++;
            analogCode = analogCode + 16'h1111;
         end
         prevBusy = convBusy;
      end
      check(rises, 16);
      startReq = 1'b0;
      for (int k = 0; k < 16; k++)
      begin
         check(resultValid, 1'b1);
         check(resultData, 16'(k * 16'h1111));
         pop();
      end
      check(resultValid, 1'b0);
      check(readBusy, 1'b0);
   endtask : fill_drain
   task automatic b_clock(input logic din, output logic b);
      repeat (6) @(negedge sys_clk);
      b = linkB.serialResultOut;
      sckB = 1'b1;
      selB = din;
      repeat (6) @(negedge sys_clk);
      sckB = 1'b0;
   endtask : b_clock
   task automatic b_start(input logic sel, input logic hold, output int n);
      selB = sel;
      @(negedge sys_clk);
      cnvB = 1'b1;
      repeat (3) @(negedge sys_clk);
      cnvB = hold;
      for (n = 3; n < 300 && convBusyB !== 1'b0; n++) @(negedge sys_clk);
      for (n = n; n < 300 && linkB.resultOe !== (hold ^ sel | !sel); n++)
         @(negedge sys_clk);
      stall(n, 300);
   endtask : b_start
   task automatic b_busy();
      logic [16:0] w;
      logic b;
      int n;
      codeB = 16'h5A3C;
      b_start(1'b1, 1'b0, n);
      check(n >= 196 && n <= 217, 1'b1);
      for (int i = 0; i < 17; i++)
      begin
         b_clock(1'b1, b);
         w = {w[15:0], b};
      end
      check(w, {1'b0, codeB});
      repeat (6) @(negedge sys_clk);
      check(linkB.resultOe, 1'b0);
      repeat (210) @(negedge sys_clk);
   endtask : b_busy
   task automatic b_early();
      logic [3:0] w;
      logic b;
      int n;
      codeB = 16'hC3A5;
      b_start(1'b1, 1'b1, n);
      repeat (4) @(negedge sys_clk);
      check(linkB.resultOe, 1'b0);
      cnvB = 1'b0;
      repeat (8) @(negedge sys_clk);
      check(linkB.resultOe, 1'b1);
      for (int i = 0; i < 4; i++)
      begin
         b_clock(1'b1, b);
         w = {w[2:0], b};
      end
      check(w, codeB[15:12]);
      cnvB = 1'b1;
      repeat (6) @(negedge sys_clk);
      check(linkB.resultOe, 1'b0);
      cnvB = 1'b0;
      repeat (210) @(negedge sys_clk);
   endtask : b_early
   task automatic b_four();
      logic [1:0] w;
      logic b;
      int n;
      codeB = 16'h96C3;
      b_start(1'b1, 1'b1, n);
      // Start stays high; select low alone opens the four-wire read.
      selB = 1'b0;
      repeat (8) @(negedge sys_clk);
      check(linkB.resultOe, 1'b1);
      for (int i = 0; i < 2; i++)
      begin
         b_clock(1'b0, b);
         w = {w[0], b};
      end
      check(w, codeB[15:14]);
      selB = 1'b1;
      repeat (6) @(negedge sys_clk);
      check(linkB.resultOe, 1'b0);
      cnvB = 1'b0;
   endtask : b_four
   task automatic b_chain();
      logic [31:0] w;
      logic [15:0] p;
      logic b;
      int n;
      codeB = 16'h3C96;
      p = 16'hE14B;
      b_start(1'b0, 1'b1, n);
      check(linkB.resultOe, 1'b1);
      for (int i = 0; i < 32; i++)
      begin
         b_clock(i < 16 ? p[15 - i] : 1'b0, b);
         w = {w[30:0], b};
      end
      check(w, {codeB, p});
      cnvB = 1'b0;
      repeat (6) @(negedge sys_clk);
      check(linkB.resultOe, 1'b0);
   endtask : b_chain
   initial
   begin
      repeat (2) @(negedge sys_clk);
      sys_rst = 1'b0;
      repeat (4) @(negedge sys_clk);
      check(link.resultOe, 1'b0);
      check(resultValid, 1'b0);
      codes();
      fill_drain();
      b_busy();
      b_early();
      b_four();
      b_chain();
      end_of_test();
   end
endmodule : sar_adc_serial_readout_tb_top
